// ---- verif/srsc_rst_src.sv ----
/* External reset source that pulls the reset pin low for a commanded time.
   Assumes go is a one-cycle pulse on pclk and low_cyc holds the low time in cycles. */
`timescale 1ns/1ns
module srsc_rst_src
(
    // Clock and command.
    input wire logic pclk,
    input wire logic go,
    input wire logic [15:0] low_cyc,
    // Pin.
    output logic reset_pin_n
);
    logic [15:0] cnt_ff = 16'h0000;
    always @(posedge pclk)
    begin
        if (go)
            cnt_ff <= low_cyc;
        else if (cnt_ff != 16'h0000)
            cnt_ff <= cnt_ff - 16'h0001;
    end
    assign reset_pin_n = (cnt_ff == 16'h0000);
endmodule : srsc_rst_src

// ---- verif/stop_mode_and_reset_control_test.sv ----
/* Self-checking bench for the standby and reset sequencer.
   Assumes STAB_BASE_CYC of 4 and a crystal input that toggles every 3 pclk cycles. */
`timescale 1ns/1ns
module stop_mode_and_reset_control_test;
    import srsc_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} srsc_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, go = 1'b0, xclk = 1'b0, pin_n;
    logic stop_exec = 1'b0, int_pending = 1'b0, wdt_overflow = 1'b0, lvd_detect = 1'b0;
    logic cpu_clk_en, xtal_osc_en, hs_osc_en, ls_osc_en, ext_clk_accept, port_hiz;
    logic sys_rst, wdt_rst, lvd_rst, stop_mode, halt_mode;
    logic [15:0] low_cyc = 16'h0000;
    int errors = 0, cmp_count = 0, xdiv = 0, n;
    srsc_row_t rows[10] = '{
        '{1'b0, SRSC_CTRL_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, SRSC_STAT_OFF, 32'h0000_0000, 32'h0000_0001, 1'b0},
        '{1'b0, SRSC_CAUSE_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, SRSC_CTRL_OFF, 32'h0000_003c, 32'h0000_0000, 1'b0},
        '{1'b0, SRSC_CTRL_OFF, 32'h0000_0000, 32'h0000_003c, 1'b0},
        '{1'b1, SRSC_STAT_OFF, 32'h0000_00ff, 32'h0000_0000, 1'b0},
        '{1'b0, SRSC_STAT_OFF, 32'h0000_0000, 32'h0000_0001, 1'b0},
        '{1'b1, 8'h10, 32'h0000_0001, 32'h0000_0000, 1'b1},
        '{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b1, SRSC_CTRL_OFF, 32'h0000_0004, 32'h0000_0000, 1'b0}};
    srsc_top #(.STAB_BASE_CYC(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_exec(stop_exec), .int_pending(int_pending),
        .wdt_overflow(wdt_overflow), .lvd_detect(lvd_detect), .reset_pin_n(pin_n),
        .main_crystal_clock(xclk), .cpu_clk_en(cpu_clk_en), .xtal_osc_en(xtal_osc_en),
        .hs_osc_en(hs_osc_en), .ls_osc_en(ls_osc_en), .ext_clk_accept(ext_clk_accept),
        .port_hiz(port_hiz), .sys_rst(sys_rst), .wdt_rst(wdt_rst), .lvd_rst(lvd_rst),
        .stop_mode(stop_mode), .halt_mode(halt_mode));
    srsc_rst_src src (.pclk(pclk), .go(go), .low_cyc(low_cyc), .reset_pin_n(pin_n));
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        xdiv <= (xdiv == 2) ? 0 : xdiv + 1;
        if (xdiv == 2)
            xclk <= ~xclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rng(input int v, input int lo, input int hi);
        cmp_count++;
        if (v < lo || v > hi)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask : rng
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits with a bound until the clock enable or the internal reset reaches v.
    task wt(input logic rst, input logic v);
        n = 0;
        while ((rst ? sys_rst : cpu_clk_en) !== v && n < 3000)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : wt
    task do_stop(input logic [31:0] ctrl, input int lo, input int hi);
        apb(1'b1, SRSC_CTRL_OFF, ctrl);
        @(posedge pclk);
        stop_exec <= 1'b1;
        @(posedge pclk);
        stop_exec <= 1'b0;
        #1;
        chk({stop_mode, cpu_clk_en, hs_osc_en, ext_clk_accept}, 32'h0000_0008);
        chk(ls_osc_en, {31'h0000_0000, !ctrl[2]});
        if (hi == 0)
            return;
        @(posedge pclk);
        int_pending <= 1'b1;
        wt(1'b0, 1'b1);
        rng(n, lo, hi);
        @(posedge pclk);
        int_pending <= 1'b0;
    endtask : do_stop
    task end_sim;
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    initial
    begin
        #300000;
        errors++;
        end_sim();
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk({cpu_clk_en, hs_osc_en, ls_osc_en, xtal_osc_en, sys_rst, lvd_rst}, 32'h38);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                chk(rd, rows[i].exp);
            chk(er, rows[i].err);
        end
        do_stop(32'h0000_0004, 2, 12);
        do_stop(32'h0000_0000, 2, 12);
        do_stop(32'h0000_0001, 508, 2015);
        do_stop(32'h0000_0003, 160 * 6 - 6, 160 * 6 + 40);
        @(posedge pclk);
        int_pending <= 1'b1;
        stop_exec <= 1'b1;
        @(posedge pclk);
        stop_exec <= 1'b0;
        #1;
        chk({halt_mode, stop_mode}, 32'h0000_0002);
        wt(1'b0, 1'b1);
        rng(n, 954, 1000);
        @(posedge pclk);
        int_pending <= 1'b0;
        do_stop(32'h0000_0008, 0, 0);
        @(posedge pclk);
        go <= 1'b1;
        low_cyc <= 16'd1300;
        @(posedge pclk);
        go <= 1'b0;
        wt(1'b1, 1'b1);
        rng(n, 1249, 1300);
        chk({stop_mode, port_hiz, lvd_rst}, 32'h0000_0006);
        chk({xtal_osc_en, hs_osc_en, ls_osc_en, ext_clk_accept}, 32'h0000_0000);
        wt(1'b1, 1'b0);
        @(posedge pclk);
        #1;
        chk({stop_mode, cpu_clk_en, port_hiz}, 32'h0000_0002);
        apb(1'b0, SRSC_CAUSE_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, SRSC_CTRL_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, SRSC_CTRL_OFF, 32'h0000_0008);
        #1;
        chk(xtal_osc_en, 32'h0000_0001);
        apb(1'b1, SRSC_CAUSE_OFF, 32'h0000_0001);
        @(posedge pclk);
        wdt_overflow <= 1'b1;
        @(posedge pclk);
        wdt_overflow <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk({sys_rst, wdt_rst, lvd_rst}, 32'h0000_0006);
        repeat (8) @(posedge pclk);
        lvd_detect <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk({sys_rst, port_hiz, lvd_rst}, 32'h0000_0006);
        @(posedge pclk);
        lvd_detect <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, SRSC_CAUSE_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0006);
        end_sim();
    end
endmodule : stop_mode_and_reset_control_test

// ---- verilog/srsc_pkg.sv ----
/*
 * Constants shared by the standby and reset sequencer: register offsets, field positions,
 * reset values, timing figures and the sequencer states.
 * Assumes a 125 MHz APB clock and 32-bit aligned register words.
 */
package srsc_pkg;
    // Register byte offsets.
    localparam logic [7:0] SRSC_CTRL_OFF = 8'h00;
    localparam logic [7:0] SRSC_STAT_OFF = 8'h04;
    localparam logic [7:0] SRSC_CAUSE_OFF = 8'h08;
    localparam logic [7:0] SRSC_STABCNT_OFF = 8'h0c;

    // Control register fields.
    localparam int SRSC_AMP_BIT = 0;
    localparam int SRSC_CLKSEL_BIT = 1;
    localparam int SRSC_LSSTOP_BIT = 2;
    localparam int SRSC_XTAL_BIT = 3;
    localparam int SRSC_STABSEL_LSB = 4;
    localparam logic [31:0] SRSC_CTRL_RST = 32'h0000_0000;

    // Reset cause fields, write one to clear.
    localparam int SRSC_CAUSE_EXT_BIT = 0;
    localparam int SRSC_CAUSE_WDT_BIT = 1;
    localparam int SRSC_CAUSE_LVD_BIT = 2;
    localparam logic [2:0] SRSC_CAUSE_RST = 3'h0;

    // Timing figures and their cycle counts.
    localparam int SRSC_CLK_PERIOD_NS = 8;
    localparam int SRSC_EXT_RST_MIN_NS = 10000;
    localparam logic [10:0] SRSC_EXT_RST_CYC =
        11'((SRSC_EXT_RST_MIN_NS + SRSC_CLK_PERIOD_NS - 1) / SRSC_CLK_PERIOD_NS);
    localparam int SRSC_HOLD_MIN_NS = 4060;
    localparam logic [23:0] SRSC_HOLD_CYC =
        24'((SRSC_HOLD_MIN_NS + SRSC_CLK_PERIOD_NS - 1) / SRSC_CLK_PERIOD_NS);
    localparam logic [23:0] SRSC_EXT_HOLD_EDGES = 24'(160);
    localparam logic [2:0] SRSC_WDT_RST_CYC = 3'h4;

    typedef enum logic [3:0] {
        SRSC_RUN = 4'b0001,
        SRSC_STOP = 4'b0010,
        SRSC_STAB = 4'b0100,
        SRSC_HOLD = 4'b1000
    } srsc_state_t;
endpackage : srsc_pkg

// ---- verilog/srsc_top.sv ----
/*
 * Standby and reset sequencer with an APB register slave.
 * Assumes stop_exec, int_pending, wdt_overflow and lvd_detect come from logic on pclk;
 * the reset pin and the external clock input arrive asynchronously.
 */
`timescale 1ns/1ns

// Summary of operation
// RULE_01 - Software restarts peripherals halted by standby.
// RULE_02 - Low-speed oscillator keeps its pre-standby state.
// RULE_03 - Software parks on internal clock before standby.
// RULE_04 - Amplifier set, internal clock: hold CPU clock.
// RULE_05 - Amplifier set, external clock: hold 160 edges.
// RULE_06 - External reset pin held low 10 us.
// RULE_07 - Reset stops oscillators, ignores external clock.
// RULE_08 - Reset keeps standby state, ports high impedance.
// RULE_09 - Voltage detector reset spares the detector.
// RULE_10 - Watchdog reset also resets the watchdog.
// RULE_11 - Pending interrupt turns standby into halt.
// RULE_12 - All reset sources merge into one reset.
module srsc_top
    import srsc_pkg::*;
#(
    parameter int STAB_BASE_CYC = 256
)(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU and system events.
    input wire logic stop_exec,
    input wire logic int_pending,
    input wire logic wdt_overflow,
    input wire logic lvd_detect,
    // Pins.
    input wire logic reset_pin_n,
    input wire logic main_crystal_clock,
    // Clock and reset control.
    output logic cpu_clk_en,
    output logic xtal_osc_en,
    output logic hs_osc_en,
    output logic ls_osc_en,
    output logic ext_clk_accept,
    output logic port_hiz,
    output logic sys_rst,
    output logic wdt_rst,
    output logic lvd_rst,
    output logic stop_mode,
    output logic halt_mode
);
    typedef struct packed {
        srsc_state_t st;
        logic amp;
        logic clksel;
        logic ls_stop;
        logic xtal;
        logic [1:0] stab_sel;
        logic amp_lat;
        logic sel_lat;
        logic [23:0] cnt;
        logic [23:0] hold_len;
        logic [10:0] ext_cnt;
        logic [2:0] wdt_cnt;
        logic [2:0] cause;
        logic rstpin_s1;
        logic rstpin_s2;
        logic eclk_s1;
        logic eclk_s2;
        logic eclk_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sys_rst;
        logic wdt_rst;
        logic lvd_rst;
        logic cpu_clk_en;
        logic xtal_en;
        logic hs_en;
        logic ls_en;
        logic eclk_accept;
        logic port_hiz;
        logic stop_mode;
        logic halt_mode;
    } srsc_regs_t;

    srsc_regs_t q_ff;
    srsc_regs_t nxt_q;
    logic ext_rst;
    logic int_rst;
    logic eclk_rise;
    logic wr_done;

    function automatic logic srsc_mapped(input logic [7:0] a);
        srsc_mapped = (a == SRSC_CTRL_OFF) || (a == SRSC_STAT_OFF) ||
            (a == SRSC_CAUSE_OFF) || (a == SRSC_STABCNT_OFF);
    endfunction : srsc_mapped

    function automatic logic [23:0] srsc_stab_len(input logic [1:0] sel);
        srsc_stab_len = 24'(STAB_BASE_CYC) << {sel, 1'b0};
    endfunction : srsc_stab_len

    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.rstpin_s1 = reset_pin_n;
        nxt_q.rstpin_s2 = q_ff.rstpin_s1;
        nxt_q.eclk_s1 = main_crystal_clock;
        nxt_q.eclk_s2 = q_ff.eclk_s1;
        nxt_q.eclk_prev = q_ff.eclk_s2;
        eclk_rise = q_ff.eclk_s2 && !q_ff.eclk_prev;
        // Only a low level that lasts the full minimum counts as an external reset.
        if (q_ff.rstpin_s2)
            nxt_q.ext_cnt = 11'h000;
        else if (q_ff.ext_cnt != SRSC_EXT_RST_CYC)
            nxt_q.ext_cnt = q_ff.ext_cnt + 11'h001;
        ext_rst = !q_ff.rstpin_s2 && (q_ff.ext_cnt == SRSC_EXT_RST_CYC); // [RULE_06]
        if (wdt_overflow)
            nxt_q.wdt_cnt = SRSC_WDT_RST_CYC;
        else if (q_ff.wdt_cnt != 3'h0)
            nxt_q.wdt_cnt = q_ff.wdt_cnt - 3'h1;
        int_rst = ext_rst || (q_ff.wdt_cnt != 3'h0) || lvd_detect; // [RULE_12]
        // APB: one wait state, write and read data complete together with pready.
        nxt_q.pready = psel && penable && !q_ff.pready;
        nxt_q.pslverr = nxt_q.pready && !srsc_mapped(paddr);
        nxt_q.prdata = 32'h0000_0000;
        if (nxt_q.pready && !pwrite)
        begin
            case (paddr)
                SRSC_CTRL_OFF: nxt_q.prdata = {26'h000_0000, q_ff.stab_sel, q_ff.xtal,
                    q_ff.ls_stop, q_ff.clksel, q_ff.amp};
                SRSC_STAT_OFF: nxt_q.prdata = {26'h000_0000, q_ff.sel_lat, q_ff.amp_lat,
                    q_ff.st};
                SRSC_CAUSE_OFF: nxt_q.prdata = {29'h0000_0000, q_ff.cause};
                SRSC_STABCNT_OFF: nxt_q.prdata = {8'h00, q_ff.cnt};
                default: nxt_q.prdata = 32'h0000_0000;
            endcase
        end
        wr_done = psel && penable && q_ff.pready && pwrite;
        // Cause flags survive the internal reset; a new cause wins over a clear.
        if (wr_done && (paddr == SRSC_CAUSE_OFF))
            nxt_q.cause = q_ff.cause & ~pwdata[2:0];
        if (ext_rst)
            nxt_q.cause[SRSC_CAUSE_EXT_BIT] = 1'b1;
        if (q_ff.wdt_cnt != 3'h0)
            nxt_q.cause[SRSC_CAUSE_WDT_BIT] = 1'b1;
        if (lvd_detect)
            nxt_q.cause[SRSC_CAUSE_LVD_BIT] = 1'b1;
        if (int_rst)
        begin
            {nxt_q.stab_sel, nxt_q.xtal, nxt_q.ls_stop, nxt_q.clksel, nxt_q.amp} =
                SRSC_CTRL_RST[5:0];
            nxt_q.cnt = 24'h00_0000;
            // A standby in progress is held for as long as reset lasts.
            nxt_q.st = (q_ff.st == SRSC_STOP) ? SRSC_STOP : SRSC_RUN; // [RULE_08]
        end
        else if (q_ff.sys_rst)
        begin
            nxt_q.st = SRSC_RUN;
        end
        else
        begin
            if (wr_done && (paddr == SRSC_CTRL_OFF))
            begin
                nxt_q.amp = pwdata[SRSC_AMP_BIT];
                nxt_q.clksel = pwdata[SRSC_CLKSEL_BIT];
                nxt_q.ls_stop = pwdata[SRSC_LSSTOP_BIT];
                nxt_q.xtal = pwdata[SRSC_XTAL_BIT];
                nxt_q.stab_sel = pwdata[SRSC_STABSEL_LSB +: 2];
            end
            case (q_ff.st)
                SRSC_RUN:
                begin
                    if (stop_exec)
                    begin
                        nxt_q.amp_lat = q_ff.amp;
                        nxt_q.sel_lat = q_ff.clksel;
                        nxt_q.cnt = 24'h00_0000;
                        nxt_q.st = int_pending ? SRSC_STAB : SRSC_STOP; // [RULE_11]
                    end
                end
                SRSC_STOP:
                begin
                    if (int_pending)
                    begin
                        nxt_q.cnt = 24'h00_0000;
                        nxt_q.st = SRSC_STAB;
                    end
                end
                SRSC_STAB:
                begin
                    nxt_q.cnt = q_ff.cnt + 24'h00_0001;
                    if (nxt_q.cnt >= srsc_stab_len(q_ff.stab_sel))
                    begin
                        nxt_q.cnt = 24'h00_0000;
                        nxt_q.st = q_ff.amp_lat ? SRSC_HOLD : SRSC_RUN;
                    end
                end
                SRSC_HOLD:
                begin
                    if (!q_ff.sel_lat || eclk_rise)
                        nxt_q.cnt = q_ff.cnt + 24'h00_0001;
                    if (!q_ff.sel_lat && (nxt_q.cnt == SRSC_HOLD_CYC)) // [RULE_04]
                        nxt_q.st = SRSC_RUN;
                    if (q_ff.sel_lat && (nxt_q.cnt == SRSC_EXT_HOLD_EDGES)) // [RULE_05]
                        nxt_q.st = SRSC_RUN;
                    if (nxt_q.st == SRSC_RUN)
                        nxt_q.cnt = 24'h00_0000;
                end
                default: nxt_q.st = SRSC_RUN;
            endcase
        end

        nxt_q.hold_len = (q_ff.st == SRSC_HOLD) ? q_ff.hold_len + 24'h00_0001 : 24'h00_0000;
        nxt_q.sys_rst = int_rst;
        nxt_q.wdt_rst = int_rst; // [RULE_10]
        // The voltage detector is cleared only by the power-level reset input.
        nxt_q.lvd_rst = 1'b0; // [RULE_09]
        nxt_q.port_hiz = int_rst; // [RULE_08]
        nxt_q.cpu_clk_en = !int_rst && (nxt_q.st == SRSC_RUN);
        nxt_q.hs_en = !int_rst && (nxt_q.st != SRSC_STOP); // [RULE_07]
        nxt_q.xtal_en = !int_rst && nxt_q.xtal && (nxt_q.st != SRSC_STOP); // [RULE_07]
        nxt_q.eclk_accept = !int_rst && (nxt_q.st != SRSC_STOP); // [RULE_07]
        // Standby does not touch the low-speed oscillator; only software or the internal reset stops it.
        nxt_q.ls_en = !int_rst && !nxt_q.ls_stop; // [RULE_02]
        nxt_q.stop_mode = nxt_q.st == SRSC_STOP;
        nxt_q.halt_mode = nxt_q.st == SRSC_STAB;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_ff <= '{st: SRSC_RUN, rstpin_s1: 1'b1, rstpin_s2: 1'b1, sys_rst: 1'b1,
                wdt_rst: 1'b1, lvd_rst: 1'b1, port_hiz: 1'b1, default: '0};
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign prdata = q_ff.prdata;
    assign pready = q_ff.pready;
    assign pslverr = q_ff.pslverr;
    assign cpu_clk_en = q_ff.cpu_clk_en;
    assign xtal_osc_en = q_ff.xtal_en;
    assign hs_osc_en = q_ff.hs_en;
    assign ls_osc_en = q_ff.ls_en;
    assign ext_clk_accept = q_ff.eclk_accept;
    assign port_hiz = q_ff.port_hiz;
    assign sys_rst = q_ff.sys_rst;
    assign wdt_rst = q_ff.wdt_rst;
    assign lvd_rst = q_ff.lvd_rst;
    assign stop_mode = q_ff.stop_mode;
    assign halt_mode = q_ff.halt_mode;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ls_keep_a: assert property (!q_ff.sys_rst && !q_ff.ls_stop |-> ls_osc_en) // [RULE_02]
        else $error("low-speed oscillator stopped without software request");
    hs_hold_a: assert property (q_ff.st == SRSC_HOLD && !q_ff.sel_lat // [RULE_04]
        && !int_rst |=> cpu_clk_en == (q_ff.hold_len >= SRSC_HOLD_CYC))
        else $error("internal clock hold-off length wrong");
    ext_hold_a: assert property (q_ff.st == SRSC_HOLD |-> !cpu_clk_en) // [RULE_05]
        else $error("cpu clock running during hold-off");
    ext_count_a: assert property (q_ff.st == SRSC_HOLD && q_ff.sel_lat // [RULE_05]
        && !eclk_rise && !int_rst |=> q_ff.st == SRSC_HOLD)
        else $error("external clock hold-off left without an edge");
    osc_off_a: assert property (sys_rst |-> !xtal_osc_en && !hs_osc_en // [RULE_07]
        && !ls_osc_en && !ext_clk_accept)
        else $error("oscillator running during reset");
    stop_kept_a: assert property (q_ff.st == SRSC_STOP && int_rst // [RULE_08]
        |=> q_ff.st == SRSC_STOP && port_hiz)
        else $error("standby state lost during reset");
    lvd_free_a: assert property (lvd_detect |=> sys_rst && !lvd_rst) // [RULE_09]
        else $error("voltage detector reset by its own reset");
    wdt_self_a: assert property (wdt_overflow |=> ##1 wdt_rst [*4]) // [RULE_10]
        else $error("watchdog not reset by its overflow");
    halt_path_a: assert property (q_ff.st == SRSC_RUN && stop_exec && int_pending // [RULE_11]
        && !int_rst && !q_ff.sys_rst |=> halt_mode && !stop_mode)
        else $error("pending interrupt did not turn standby into halt");
    ext_rst_a: assert property (!q_ff.rstpin_s2 // [RULE_12]
        && q_ff.ext_cnt == SRSC_EXT_RST_CYC |=> sys_rst && q_ff.cause[SRSC_CAUSE_EXT_BIT])
        else $error("qualified external reset not applied");

    stop_wake_c: cover property (q_ff.st == SRSC_STOP ##1 q_ff.st == SRSC_STAB);
    hold_done_c: cover property (q_ff.st == SRSC_HOLD ##1 q_ff.st == SRSC_RUN);
    ext_reset_c: cover property ($rose(q_ff.cause[SRSC_CAUSE_EXT_BIT]));
endmodule : srsc_top
